// File: hw/eis_regs.vh
`ifndef EIS_REGS_VH
`define EIS_REGS_VH

// register indices, byte address is four times the index
`define EIS_IDX_PA_DATA   6'h00
`define EIS_IDX_PA_DIR    6'h01
`define EIS_IDX_PA_OPT    6'h02
`define EIS_IDX_PB_DATA   6'h03
`define EIS_IDX_PB_DIR    6'h04
`define EIS_IDX_PB_OPT    6'h05
`define EIS_IDX_PC_DATA   6'h06
`define EIS_IDX_PC_DIR    6'h07
`define EIS_IDX_SENSE     6'h08
`define EIS_IDX_SELECT    6'h09
`define EIS_IDX_STATUS    6'h0a
`define EIS_IDX_CLEAR     6'h0b
`define EIS_IDX_ENABLE    6'h0c
`define EIS_IDX_PA_PINS   6'h0d
`define EIS_IDX_PB_PINS   6'h0e
`define EIS_IDX_PC_PINS   6'h0f
`define EIS_IDX_LAST      6'h0f

// reset values
`define EIS_RST_PA_DATA   8'hff
`define EIS_RST_PA_DIR    8'h00
`define EIS_RST_PA_OPT    8'h00
`define EIS_RST_PB_DATA   7'h00
`define EIS_RST_PB_DIR    7'h00
`define EIS_RST_PB_OPT    7'h00
`define EIS_RST_PC_DATA   2'h0
`define EIS_RST_PC_DIR    2'h0
`define EIS_RST_SENSE     8'h00
`define EIS_RST_SELECT    8'h0c
`define EIS_RST_ENABLE    4'h0

// sensitivity codes
`define EIS_SENSE_FALL_LOW 2'h0
`define EIS_SENSE_RISE     2'h1
`define EIS_SENSE_FALL     2'h2
`define EIS_SENSE_BOTH     2'h3

// source select field positions and codes
`define EIS_SEL_L3_HI     7
`define EIS_SEL_L3_LO     6
`define EIS_SEL_L2_HI     5
`define EIS_SEL_L2_LO     4
`define EIS_SEL_L3_NONE   2'h3
`define EIS_SEL_L2_HALT   2'h1
`define EIS_L2_BASE_BIT   3'h3

// port A bits feeding lines 1 and 0
`define EIS_L1_PA_BIT     7
`define EIS_L0_PA_BIT     0

`endif

// File: hw/eis_sync.v
`timescale 1ns/1ns
module eis_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // eis_sync

// File: hw/eis_line.v
`timescale 1ns/1ns
`include "eis_regs.vh"
module eis_line (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_level,
  input  wire       i_enable,
  input  wire [1:0] i_mode,
  input  wire       i_restart,
  input  wire       i_sense_chg,
  input  wire       i_clear,
  output wire       o_pending
);
  reg  prev_q;
  reg  pend_q;
  reg  pend_d;
  reg  event_d;
  wire rise;
  wire fall;

  assign rise = i_level & ~prev_q;
  assign fall = ~i_level & prev_q;

  always @* begin
    case (i_mode)
      `EIS_SENSE_FALL_LOW: event_d = ~i_level;
      `EIS_SENSE_RISE:     event_d = rise;
      `EIS_SENSE_FALL:     event_d = fall;
      `EIS_SENSE_BOTH:     event_d = rise | fall;
      default:             event_d = 1'b0;
    endcase
    // a pin switch or mode change looks like an edge, so that cycle is blanked
    if (!i_enable || i_restart || i_sense_chg) begin
      event_d = 1'b0;
    end
    if (i_sense_chg) begin
      pend_d = 1'b0;
    end else begin
      pend_d = event_d | (pend_q & ~i_clear);
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev_q <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      prev_q <= i_level;
      pend_q <= pend_d;
    end
  end

  assign o_pending = pend_q;
endmodule // eis_line

// File: hw/eis_top.v
`timescale 1ns/1ns
`include "eis_regs.vh"
module eis_top #(
  parameter ADDR_W = 8
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  // apb slave
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [ADDR_W-1:0] i_paddr,
  input  wire [31:0]       i_pwdata,
  output wire [31:0]       o_prdata,
  output wire              o_pready,
  output wire              o_pslverr,
  // core side
  input  wire              i_core_imask,
  input  wire              i_halt,
  input  wire [3:0]        i_irq_ack,
  input  wire [1:0]        i_osc_sel,
  output wire [3:0]        o_ext_req,
  output wire              o_irq,
  // port A pins
  input  wire [7:0]        i_pa_in,
  output wire [7:0]        o_pa_out,
  output wire [7:0]        o_pa_oe,
  output wire [7:0]        o_pa_pullup,
  // port B pins
  input  wire [6:0]        i_pb_in,
  output wire [6:0]        o_pb_out,
  output wire [6:0]        o_pb_oe,
  output wire [6:0]        o_pb_pullup,
  // port C pins
  input  wire [1:0]        i_pc_in,
  output wire [1:0]        o_pc_out,
  output wire [1:0]        o_pc_oe
);
  // interrupt capability of a standard pin: input with option set
  function cap_f;
    input dir;
    input opt;
    begin
      cap_f = ~dir & opt;
    end
  endfunction

  // write strobe for one register index
  function wr_hit_f;
    input       wr_en;
    input [5:0] at;
    input [5:0] want;
    begin
      wr_hit_f = wr_en & (at == want);
    end
  endfunction

  // a two-bit field that the write in flight would alter
  function field_chg_f;
    input       wr_en;
    input [1:0] old_v;
    input [1:0] new_v;
    begin
      field_chg_f = wr_en & (old_v != new_v);
    end
  endfunction

  reg  [7:0]  pa_data_q;
  reg  [7:0]  pa_dir_q;
  reg  [7:0]  pa_opt_q;
  reg  [6:0]  pb_data_q;
  reg  [6:0]  pb_dir_q;
  reg  [6:0]  pb_opt_q;
  reg  [1:0]  pc_data_q;
  reg  [1:0]  pc_dir_q;
  reg  [7:0]  sense_q;
  reg  [7:0]  select_q;
  reg  [3:0]  enable_q;
  reg  [31:0] prdata_q;
  reg  [31:0] prdata_d;
  reg  [3:0]  restart_q;

  wire [5:0]  idx;
  wire        mapped;
  wire        setup;
  wire        access;
  wire        wr;
  wire [7:0]  wbyte;
  wire        sense_wr;
  wire [7:0]  sense_new;
  wire [3:0]  sense_chg;
  wire        select_wr;
  wire [3:0]  restart;
  wire [3:0]  clear;
  wire [3:0]  pending;
  wire [3:0]  line_level;
  wire [3:0]  line_en;
  wire [7:0]  pa_s;
  wire [6:0]  pb_s;
  wire [1:0]  pc_s;
  wire [1:0]  l3_sel;
  wire [1:0]  l2_sel;
  wire [2:0]  l2_bit;
  wire [1:0]  pc_port;
  wire        pa_data_wr;
  wire        pa_dir_wr;
  wire        pa_opt_wr;
  wire        pb_data_wr;
  wire        pb_dir_wr;
  wire        pb_opt_wr;
  wire        pc_data_wr;
  wire        pc_dir_wr;
  wire        enable_wr;
  wire        clear_wr;

  // bus decode
  assign idx    = i_paddr[ADDR_W-1:2];
  assign mapped = (idx <= `EIS_IDX_LAST) && (i_paddr[1:0] == 2'h0);
  assign setup  = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr     = access & i_pwrite & mapped;
  assign wbyte  = i_pwdata[7:0];

  // one strobe per writable register keeps the update logic flat
  assign pa_data_wr = wr_hit_f(wr, idx, `EIS_IDX_PA_DATA);
  assign pa_dir_wr  = wr_hit_f(wr, idx, `EIS_IDX_PA_DIR);
  assign pa_opt_wr  = wr_hit_f(wr, idx, `EIS_IDX_PA_OPT);
  assign pb_data_wr = wr_hit_f(wr, idx, `EIS_IDX_PB_DATA);
  assign pb_dir_wr  = wr_hit_f(wr, idx, `EIS_IDX_PB_DIR);
  assign pb_opt_wr  = wr_hit_f(wr, idx, `EIS_IDX_PB_OPT);
  assign pc_data_wr = wr_hit_f(wr, idx, `EIS_IDX_PC_DATA);
  assign pc_dir_wr  = wr_hit_f(wr, idx, `EIS_IDX_PC_DIR);
  assign enable_wr  = wr_hit_f(wr, idx, `EIS_IDX_ENABLE);
  assign clear_wr   = wr_hit_f(wr, idx, `EIS_IDX_CLEAR);

  // read data is captured in setup so the access phase can finish at once
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign o_prdata  = prdata_q;

  // pin synchronisers
  eis_sync #(
    .WIDTH (8)
  ) u_sync_pa (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pa_in),
    .o_sync  (pa_s)
  );

  eis_sync #(
    .WIDTH (7)
  ) u_sync_pb (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pb_in),
    .o_sync  (pb_s)
  );

  eis_sync #(
    .WIDTH (2)
  ) u_sync_pc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pc_in),
    .o_sync  (pc_s)
  );

  // sensitivity writes with the core mask clear are dropped silently
  assign sense_wr  = wr_hit_f(wr, idx, `EIS_IDX_SENSE) & i_core_imask;
  assign sense_new = sense_wr ? wbyte : sense_q;
  assign sense_chg[0] = field_chg_f(sense_wr, sense_q[1:0], wbyte[1:0]);
  assign sense_chg[1] = field_chg_f(sense_wr, sense_q[3:2], wbyte[3:2]);
  assign sense_chg[2] = field_chg_f(sense_wr, sense_q[5:4], wbyte[5:4]);
  assign sense_chg[3] = field_chg_f(sense_wr, sense_q[7:6], wbyte[7:6]);

  // source selection
  assign select_wr = wr_hit_f(wr, idx, `EIS_IDX_SELECT);
  assign l3_sel = select_q[`EIS_SEL_L3_HI:`EIS_SEL_L3_LO];
  assign l2_sel = select_q[`EIS_SEL_L2_HI:`EIS_SEL_L2_LO];
  assign l2_bit = `EIS_L2_BASE_BIT + {1'b0, l2_sel};

  assign restart[0] = 1'b0;
  assign restart[1] = 1'b0;
  assign restart[2] = field_chg_f(select_wr, l2_sel,
                                  wbyte[`EIS_SEL_L2_HI:`EIS_SEL_L2_LO]);
  assign restart[3] = field_chg_f(select_wr, l3_sel,
                                  wbyte[`EIS_SEL_L3_HI:`EIS_SEL_L3_LO]);

  // lines 0 and 1 have fixed port A sources; port C is never routed here
  assign line_level[0] = pa_s[`EIS_L0_PA_BIT];
  assign line_level[1] = pa_s[`EIS_L1_PA_BIT];
  assign line_level[2] = pb_s[l2_bit];
  assign line_level[3] = (l3_sel == `EIS_SEL_L3_NONE) ? 1'b1 : pb_s[l3_sel];

  assign line_en[0] = cap_f(pa_dir_q[`EIS_L0_PA_BIT], pa_opt_q[`EIS_L0_PA_BIT]);
  assign line_en[1] = cap_f(pa_dir_q[`EIS_L1_PA_BIT], pa_opt_q[`EIS_L1_PA_BIT]);
  assign line_en[2] = cap_f(pb_dir_q[l2_bit], pb_opt_q[l2_bit])
                      & ~(i_halt & (l2_sel == `EIS_SEL_L2_HALT));
  // code 11 on line 3 selects no pin, so the line stays quiet
  assign line_en[3] = (l3_sel != `EIS_SEL_L3_NONE)
                      & cap_f(pb_dir_q[l3_sel], pb_opt_q[l3_sel]);

  // clear by acknowledge or by the clear register; a new event still wins
  assign clear = i_irq_ack
                 | ({4{clear_wr}} & wbyte[3:0]);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_line
      eis_line u_line (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_level     (line_level[g]),
        .i_enable    (line_en[g]),
        .i_mode      (sense_q[2*g+1:2*g]),
        .i_restart   (restart_q[g]),
        .i_sense_chg (sense_chg[g]),
        .i_clear     (clear[g]),
        .o_pending   (pending[g])
      );
    end
  endgenerate

  assign o_ext_req = pending;
  assign o_irq     = |(pending & enable_q);

  // port A registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pa_data_q <= `EIS_RST_PA_DATA;
      pa_dir_q  <= `EIS_RST_PA_DIR;
      pa_opt_q  <= `EIS_RST_PA_OPT;
    end else begin
      if (pa_data_wr) begin
        pa_data_q <= wbyte;
      end
      if (pa_dir_wr) begin
        pa_dir_q <= wbyte;
      end
      if (pa_opt_wr) begin
        pa_opt_q <= wbyte;
      end
    end
  end

  // port B and C registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pb_data_q <= `EIS_RST_PB_DATA;
      pb_dir_q  <= `EIS_RST_PB_DIR;
      pb_opt_q  <= `EIS_RST_PB_OPT;
      pc_data_q <= `EIS_RST_PC_DATA;
      pc_dir_q  <= `EIS_RST_PC_DIR;
    end else begin
      if (pb_data_wr) begin
        pb_data_q <= wbyte[6:0];
      end
      if (pb_dir_wr) begin
        pb_dir_q <= wbyte[6:0];
      end
      if (pb_opt_wr) begin
        pb_opt_q <= wbyte[6:0];
      end
      if (pc_data_wr) begin
        pc_data_q <= wbyte[1:0];
      end
      if (pc_dir_wr) begin
        pc_dir_q <= wbyte[1:0];
      end
    end
  end

  // interrupt control registers
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sense_q   <= `EIS_RST_SENSE;
      select_q  <= `EIS_RST_SELECT;
      enable_q  <= `EIS_RST_ENABLE;
      restart_q <= 4'h0;
    end else begin
      sense_q   <= sense_new;
      // the new pin is only seen after the select edge, so the blank lands one cycle later
      restart_q <= restart;
      if (select_wr) begin
        select_q <= wbyte;
      end
      if (enable_wr) begin
        enable_q <= wbyte[3:0];
      end
    end
  end

  // read mux, only the low byte carries data
  always @* begin
    prdata_d = 32'h0000_0000;
    case (idx)
      `EIS_IDX_PA_DATA: prdata_d[7:0] = pa_data_q;
      `EIS_IDX_PA_DIR:  prdata_d[7:0] = pa_dir_q;
      `EIS_IDX_PA_OPT:  prdata_d[7:0] = pa_opt_q;
      `EIS_IDX_PB_DATA: prdata_d[6:0] = pb_data_q;
      `EIS_IDX_PB_DIR:  prdata_d[6:0] = pb_dir_q;
      `EIS_IDX_PB_OPT:  prdata_d[6:0] = pb_opt_q;
      `EIS_IDX_PC_DATA: prdata_d[1:0] = pc_data_q;
      `EIS_IDX_PC_DIR:  prdata_d[1:0] = pc_dir_q;
      `EIS_IDX_SENSE:   prdata_d[7:0] = sense_q;
      `EIS_IDX_SELECT:  prdata_d[7:0] = select_q;
      `EIS_IDX_STATUS:  prdata_d[3:0] = pending;
      `EIS_IDX_ENABLE:  prdata_d[3:0] = enable_q;
      `EIS_IDX_PA_PINS: prdata_d[7:0] = pa_s;
      `EIS_IDX_PB_PINS: prdata_d[6:0] = pb_s;
      `EIS_IDX_PC_PINS: prdata_d[1:0] = pc_s & pc_port;
      default:          prdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      // a refused read returns zero, not the register its index points at
      prdata_q <= mapped ? prdata_d : 32'h0000_0000;
    end
  end

  // standard pins: open drain only drives while the data bit is low
  assign o_pa_out    = pa_data_q;
  assign o_pa_oe     = pa_dir_q & (pa_opt_q | ~pa_data_q);
  assign o_pa_pullup = ~pa_dir_q & pa_opt_q;
  assign o_pb_out    = pb_data_q;
  assign o_pb_oe     = pb_dir_q & (pb_opt_q | ~pb_data_q);
  assign o_pb_pullup = ~pb_dir_q & pb_opt_q;

  // port C has no option bit: output is push-pull, and a pin taken by i_osc_sel is never driven
  assign pc_port  = ~i_osc_sel;
  assign o_pc_out = pc_data_q;
  assign o_pc_oe  = pc_dir_q & pc_port;
endmodule // eis_top

// File: test/eis_top_chk.sv
`timescale 1ns/1ns
module eis_top_chk #(
  parameter ADDR_W = 8
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic [3:0]        i_irq_ack,
  input wire logic [1:0]        i_osc_sel,
  input wire logic [3:0]        o_ext_req,
  input wire logic              o_irq,
  input wire logic [7:0]        i_pa_in,
  input wire logic [7:0]        o_pa_oe,
  input wire logic [7:0]        o_pa_pullup,
  input wire logic [6:0]        o_pb_oe,
  input wire logic [6:0]        o_pb_pullup,
  input wire logic [1:0]        o_pc_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire acc = i_psel && i_penable;
  property p_pa_excl; (o_pa_oe & o_pa_pullup) == 8'h00; endproperty
  a_pa_excl: assert property (p_pa_excl) else $error("port a drives and pulls up");
  property p_pb_excl; (o_pb_oe & o_pb_pullup) == 7'h00; endproperty
  a_pb_excl: assert property (p_pb_excl) else $error("port b drives and pulls up");
  property p_osc; (o_pc_oe & i_osc_sel) == 2'b00; endproperty
  a_osc: assert property (p_osc) else $error("oscillator pin driven");
  property p_err_phase; o_pslverr |-> acc; endproperty
  a_err_phase: assert property (p_err_phase) else $error("slave error outside access");
  property p_misalign; acc && i_paddr[1:0] != 2'b00 |-> o_pslverr; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
  property p_misalign_rd;
    acc && !i_pwrite && i_paddr[1:0] != 2'b00 |-> o_prdata == 32'h0;
  endproperty
  a_misalign_rd: assert property (p_misalign_rd) else $error("misaligned read data");
  property p_ready; i_psel |-> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_ack0; i_pa_in[0] [*5] ##0 i_irq_ack[0] |=> !o_ext_req[0]; endproperty
  a_ack0: assert property (p_ack0) else $error("ack left line 0 pending");
  property p_fell; $fell(o_ext_req[0]) |-> $past(i_irq_ack[0]) || $past(acc && i_pwrite); endproperty
  a_fell: assert property (p_fell) else $error("line 0 request dropped alone");
  property p_irq; o_irq |-> o_ext_req != 4'h0; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without request");
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (o_pslverr);
  c_l2: cover property ($rose(o_ext_req[2]));
endmodule // eis_top_chk
bind eis_top eis_top_chk #(.ADDR_W(ADDR_W)) u_eis_top_chk (.i_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_irq_ack, .i_osc_sel,
  .o_ext_req, .o_irq, .i_pa_in, .o_pa_oe, .o_pa_pullup, .o_pb_oe, .o_pb_pullup, .o_pc_oe);

// File: test/eis_pin_model.sv
`timescale 1ns/1ns
module eis_pin_model #(
  parameter W = 8
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_pullup,
  input  wire logic [W-1:0] i_ext,
  input  wire logic [W-1:0] i_ext_en,
  output wire logic [W-1:0] o_pin
);
  // an undriven floating pin wanders, so nothing may rely on it
  reg [W-1:0] wander_q = '0;
  always @(posedge i_clk) begin
    wander_q <= ~wander_q;
  end
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
               | (~i_oe & ~i_ext_en & (i_pullup | wander_q));
endmodule // eis_pin_model

// File: test/eis_top_tb.sv
`timescale 1ns/1ns
`include "eis_regs.vh"
module eis_top_tb;
  reg         clk, rst_n, psel, penable, pwrite, imask, halt, err_seen;
  reg  [7:0]  paddr, pa_ext, pa_en;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  ack;
  reg  [1:0]  osc, pc_ext, pc_en;
  reg  [6:0]  pb_ext, pb_en;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [3:0]  req;
  wire [7:0]  pa_in, pa_out, pa_oe, pa_pu;
  wire [6:0]  pb_in, pb_out, pb_oe, pb_pu;
  wire [1:0]  pc_in, pc_out, pc_oe;
  integer     errors, checks_done, m, k, s;
  eis_top u_eis_top (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_core_imask(imask), .i_halt(halt),
    .i_irq_ack(ack), .i_osc_sel(osc), .o_ext_req(req), .o_irq(irq), .i_pa_in(pa_in),
    .o_pa_out(pa_out), .o_pa_oe(pa_oe), .o_pa_pullup(pa_pu), .i_pb_in(pb_in),
    .o_pb_out(pb_out), .o_pb_oe(pb_oe), .o_pb_pullup(pb_pu), .i_pc_in(pc_in),
    .o_pc_out(pc_out), .o_pc_oe(pc_oe));
  eis_pin_model #(.W(8)) u_pins_a (.i_clk(clk), .i_out(pa_out), .i_oe(pa_oe),
    .i_pullup(pa_pu), .i_ext(pa_ext), .i_ext_en(pa_en), .o_pin(pa_in));
  eis_pin_model #(.W(7)) u_pins_b (.i_clk(clk), .i_out(pb_out), .i_oe(pb_oe),
    .i_pullup(pb_pu), .i_ext(pb_ext), .i_ext_en(pb_en), .o_pin(pb_in));
  eis_pin_model #(.W(2)) u_pins_c (.i_clk(clk), .i_out(pc_out), .i_oe(pc_oe),
    .i_pullup(2'b00), .i_ext(pc_ext), .i_ext_en(pc_en), .o_pin(pc_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [95:0] name, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task apb(input [5:0] idx, input [1:0] lo, input wr, input [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, lo};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [5:0] idx, input [7:0] d);
    apb(idx, 2'b00, 1'b1, d);
  endtask
  task rchk(input [5:0] idx, input [7:0] exp);
    begin
      apb(idx, 2'b00, 1'b0, 8'h00);
      chk("register", {24'h0, exp}, rd);
    end
  endtask
  task pulse(input [3:0] a);
    begin
      ack <= a;
      @(posedge clk);
      ack <= 4'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task results;
    begin
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    results;
  end
  initial begin
    errors = 0;
    checks_done = 0;
    {rst_n, psel, penable, pwrite, halt, paddr, pwdata, ack, osc, pc_ext} = '0;
    imask = 1'b1;
    pa_ext = 8'hff;
    pa_en = 8'hff;
    pb_ext = 7'h7f;
    pb_en = 7'h7f;
    pc_en = 2'b11;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`EIS_IDX_PA_DATA, 8'hff);
    rchk(`EIS_IDX_SENSE, 8'h00);
    rchk(`EIS_IDX_SELECT, 8'h0c);
    rchk(`EIS_IDX_ENABLE, 8'h00);
    apb(6'h10, 2'b00, 1'b0, 8'h00);
    chk("unmapped", 32'h1, err_seen);
    apb(`EIS_IDX_SELECT, 2'b10, 1'b0, 8'h00);
    chk("misalign", 32'h1, err_seen);
    chk("misalign_rd", 32'h0, rd);
    apb(`EIS_IDX_SENSE, 2'b01, 1'b1, 8'hff);
    imask <= 1'b0;
    wr(`EIS_IDX_SENSE, 8'he4);
    rchk(`EIS_IDX_SENSE, 8'h00);
    imask <= 1'b1;
    wr(`EIS_IDX_SENSE, 8'he4);
    rchk(`EIS_IDX_SENSE, 8'he4);
    // open-drain bit 5 released, pull-ups on 3:2, outside drives 5 and 1:0 low
    pa_ext <= 8'h00;
    pa_en <= 8'hf3;
    wr(`EIS_IDX_PA_DIR, 8'hf0);
    wr(`EIS_IDX_PA_OPT, 8'hcc);
    wr(`EIS_IDX_PA_DATA, 8'haa);
    @(posedge clk);
    chk("pa_oe", 32'hd0, pa_oe);
    chk("pa_pullup", 32'h0c, pa_pu);
    rchk(`EIS_IDX_PA_PINS, 8'h8c);
    osc <= 2'b10;
    wr(`EIS_IDX_PC_DIR, 8'h03);
    wr(`EIS_IDX_PC_DATA, 8'h03);
    @(posedge clk);
    chk("pc_oe", 32'h1, pc_oe);
    chk("pc_out", 32'h3, pc_out);
    rchk(`EIS_IDX_PC_PINS, 8'h01);
    wr(`EIS_IDX_PC_DIR, 8'h00);
    pa_ext <= 8'hff;
    pa_en <= 8'hff;
    wr(`EIS_IDX_PA_DIR, 8'h00);
    wr(`EIS_IDX_PA_OPT, 8'h81);
    wr(`EIS_IDX_ENABLE, 8'h0f);
    for (m = 0; m < 4; m = m + 1) begin
      wr(`EIS_IDX_SENSE, {4'h0, m[1:0], m[1:0]});
      pa_ext <= 8'h7e;
      repeat (5) @(posedge clk);
      chk("req_fall", {2{m != 1}}, req[1:0]);
      chk("irq", m != 1, irq);
      pulse(4'h3);
      chk("req_level", {2{m == 0}}, req[1:0]);
      pa_ext <= 8'hff;
      repeat (5) @(posedge clk);
      chk("req_rise", {2{m != 2}}, req[1:0]);
      pulse(4'h3);
      chk("req_ack", 32'h0, req[1:0]);
    end
    wr(`EIS_IDX_ENABLE, 8'h0e);
    pa_ext <= 8'h7e;
    repeat (5) @(posedge clk);
    chk("irq_enabled", 32'h1, irq);
    wr(`EIS_IDX_ENABLE, 8'h0c);
    @(posedge clk);
    chk("irq_masked", 32'h0, irq);
    wr(`EIS_IDX_SENSE, 8'h0d);
    rchk(`EIS_IDX_STATUS, 8'h02);
    wr(`EIS_IDX_CLEAR, 8'h02);
    rchk(`EIS_IDX_STATUS, 8'h00);
    rchk(`EIS_IDX_CLEAR, 8'h00);
    pa_ext <= 8'hff;
    wr(`EIS_IDX_PB_OPT, 8'h7f);
    @(posedge clk);
    chk("pb_pullup", 32'h7f, pb_pu);
    wr(`EIS_IDX_SENSE, 8'ha0);
    for (k = 0; k < 5; k = k + 1) begin
      s = (k == 4) ? 1 : k;
      halt <= (k == 4);
      wr(`EIS_IDX_SELECT, {s[1:0], s[1:0], 4'hc});
      pb_ext <= 7'h7f;
      repeat (5) @(posedge clk);
      wr(`EIS_IDX_CLEAR, 8'h0f);
      pb_ext <= 7'h7f & ~(7'h01 << s) & ~(7'h08 << s);
      pc_ext <= pc_ext ^ 2'b11;
      repeat (5) @(posedge clk);
      rchk(`EIS_IDX_STATUS, {4'h0, s != 3, k != 4, 2'b00});
    end
    halt <= 1'b0;
    wr(`EIS_IDX_SELECT, 8'h0c);
    pb_ext <= 7'h7e;
    repeat (5) @(posedge clk);
    wr(`EIS_IDX_SENSE, 8'hc0);
    wr(`EIS_IDX_SELECT, 8'h4c);
    repeat (5) @(posedge clk);
    rchk(`EIS_IDX_STATUS, 8'h00);
    results;
  end
endmodule // eis_top_tb
